// ---- rtl/rssw_defines.svh ----
`ifndef RSSW_DEFINES_SVH
`define RSSW_DEFINES_SVH

// Register byte addresses on APB.
`define RSSW_ADDR_CONFIG 8'h00
`define RSSW_ADDR_INTCTL 8'h04
`define RSSW_ADDR_STATUS 8'h08
`define RSSW_ADDR_WDTCTL 8'h0c
`define RSSW_ADDR_EVSTAT 8'h10
`define RSSW_ADDR_EVMASK 8'h14
`define RSSW_ADDR_CONTROL 8'h18

// Configuration register fields.
`define RSSW_CFG_EXT_RESET_PIN_ENABLE_BIT 0
`define RSSW_CFG_LVP_BIT 1
`define RSSW_CFG_POWERUP_DELAY_ENABLE_N_N_BIT 2
`define RSSW_CFG_WPU_BIT 3
`define RSSW_CFG_RESET 8'h04

// Core status flag positions.
`define RSSW_ST_PD_BIT 3
`define RSSW_ST_TO_BIT 4
`define RSSW_ST_RESET 8'h18

// Interrupt control: enables in 5:3, flags in 2:0, global enable in 7.
`define RSSW_IC_GIE_BIT 7
`define RSSW_IC_RESET 8'h00
`define RSSW_WDT_RESET 8'h16

// Event status bits.
`define RSSW_EV_WDT_RST 0
`define RSSW_EV_WAKE 1
`define RSSW_EV_EXT_RST 2
`define RSSW_EV_RUN 3
`define RSSW_EV_W 4

// Control register: write-one pulses.
`define RSSW_CT_SLEEP_BIT 0
`define RSSW_CT_WATCHDOG_CLEAR_INSTR_BIT 1

// Timing.
`define RSSW_CLK_HZ 50000000
`define RSSW_POWERUP_DELAY_TIMER_MS 64
`define RSSW_POWERUP_DELAY_TIMER_CYC ((`RSSW_CLK_HZ / 1000) * `RSSW_POWERUP_DELAY_TIMER_MS)
`define RSSW_START_CYC 10
`define RSSW_FILT_CYC 8

`endif

// ---- rtl/rssw_pkg.sv ----
package rssw_pkg;
	typedef enum logic [2:0] {
		ST_POR,
		ST_POWERUP_DELAY_TIMER,
		ST_WAIT_PIN,
		ST_START,
		ST_RUN,
		ST_SLEEP
	} rssw_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic sel;
		logic enable;
		logic [31:0] wdata;
	} rssw_apb_req_s;

	typedef struct packed {
		logic low_voltage_program_enable;
		logic ext_reset_pin_enable;
		logic powerup_delay_enable_n;
		logic wpu_sw;
	} rssw_cfg_s;
endpackage

// ---- rtl/rssw_ctrl.sv ----
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
// Behaviour
// - Pin reset enabled if LOW_VOLTAGE_PROGRAM_ENABLE or enable bit.
// - Low enabled pin holds device in reset.
// - Short pin pulses are filtered and ignored.
// - Reset never drives the pin low.
// - Disabled pin is input; pull-up software-controlled.
// - Watchdog expiry in run resets, updates expiry/powerdown flags.
// - Programming exit behaves like power-on reset.
// - Optional power-up delay after POR or BOR.
// - Nominal 64 ms delay, enabled when bit cleared.
// - Delay starts after POR and BOR released.
// - Run after delay, then pin release.
// - Delay counts regardless of pin state.
// - Pin release after delay: run in 10 cycles.
// - Wake decision ignores global interrupt enable.
// - Pending interrupt makes sleep a no-op.
// - Interrupt during sleep wakes, clears watchdog, flags.
`include "rssw_defines.svh"

module rssw_ctrl #(
	parameter int unsigned POWERUP_DELAY_TIMER_CYC = `RSSW_POWERUP_DELAY_TIMER_CYC,
	parameter int unsigned FILT_CYC = `RSSW_FILT_CYC
) (
	input wire logic pclk, // APB clock, 50 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error for unmapped address
	input wire logic por_active, // Power-on reset condition, async
	input wire logic bor_active, // Brown-out reset condition, async
	input wire logic prog_mode, // Programming mode active, async
	input wire logic wdt_expired, // Watchdog period expired pulse
	input wire logic [2:0] irq_flag_in, // Interrupt source flag sets
	input wire logic ext_reset_pin_n_i, // Reset pin level, async
	output logic ext_reset_pin_n_o, // Reset pin drive value
	output logic ext_reset_pin_n_oe, // Reset pin drive enable
	output logic pin_pullup_en, // Weak pull-up on the pin
	output logic pin_gpio_in, // Pin as general input
	output logic core_reset_n, // Core held in reset while low
	output logic sleeping, // Core clock gated for sleep
	output logic wdt_clear, // Watchdog and prescaler clear pulse
	output logic irq // Level interrupt
);
	import rssw_pkg::*;

	rssw_state_e state_q, state_d;
	rssw_cfg_s cfg;
	logic [7:0] cfg_q, intctl_q, status_q, wdtctl_q, evmask_q;
	logic [`RSSW_EV_W-1:0] ev_q;
	logic [2:0] sync_q, filt_sync;
	logic [31:0] cnt_q;
	logic [7:0] filt_cnt_q;
	logic pin_low_q, wdt_clr_q, prog_d_q;

	assign cfg = '{cfg_q[`RSSW_CFG_LVP_BIT], cfg_q[`RSSW_CFG_EXT_RESET_PIN_ENABLE_BIT],
		cfg_q[`RSSW_CFG_POWERUP_DELAY_ENABLE_N_N_BIT], cfg_q[`RSSW_CFG_WPU_BIT]};

	wire pin_en = cfg.low_voltage_program_enable | cfg.ext_reset_pin_enable;
	assign ext_reset_pin_n_o = 1'b1;
	assign ext_reset_pin_n_oe = 1'b0;
	assign pin_pullup_en = pin_en ? 1'b1 : cfg.wpu_sw;
	assign pin_gpio_in = pin_en ? 1'b0 : filt_sync[2];

	// Synchroniser: stage 0 feeds stage 1 only; the rest reads stage 1.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= 3'h7;
		end else begin
			sync_q <= {sync_q[1], sync_q[0], ext_reset_pin_n_i};
		end
	end
	assign filt_sync = {sync_q[1], sync_q[1], sync_q[1]};

	logic [2:0] psync_q, bsync_q, gsync_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psync_q <= 3'h0;
			bsync_q <= 3'h0;
			gsync_q <= 3'h0;
		end else begin
			psync_q <= {psync_q[1:0], por_active};
			bsync_q <= {bsync_q[1:0], bor_active};
			gsync_q <= {gsync_q[1:0], prog_mode};
		end
	end
	wire por_s = psync_q[1];
	wire bor_s = bsync_q[1];
	wire prog_s = gsync_q[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_cnt_q <= 8'h00;
			pin_low_q <= 1'b0;
		end else if (sync_q[1]) begin
			filt_cnt_q <= 8'h00;
			pin_low_q <= 1'b0;
		end else if (filt_cnt_q >= 8'(FILT_CYC - 1)) begin
			pin_low_q <= 1'b1;
		end else begin
			filt_cnt_q <= filt_cnt_q + 8'h01;
		end
	end

	wire pin_hold = pin_en & pin_low_q;
	wire prog_exit = prog_d_q & ~prog_s;
	wire power_rst = por_s | bor_s | prog_s | prog_exit;

	wire [7:0] irq_en = {5'h00, intctl_q[5:3]};
	wire [7:0] irq_fl = {5'h00, intctl_q[2:0]};
	wire wake_pend = |(irq_en & irq_fl);

	// Register hit: each register is one aligned word at its own byte address.
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		reg_hit = (a == off);
	endfunction

	// APB access: zero wait states.
	wire wr = psel & penable & pwrite;
	wire rd_ok = (paddr <= `RSSW_ADDR_CONTROL) && (paddr[1:0] == 2'b00);
	wire wr_ctl = wr & rd_ok & reg_hit(paddr, `RSSW_ADDR_CONTROL);
	wire wr_cfg = wr & reg_hit(paddr, `RSSW_ADDR_CONFIG);
	wire wr_ic = wr & reg_hit(paddr, `RSSW_ADDR_INTCTL);
	wire wr_st = wr & reg_hit(paddr, `RSSW_ADDR_STATUS);
	wire wr_wdt = wr & reg_hit(paddr, `RSSW_ADDR_WDTCTL);
	wire wr_ev = wr & reg_hit(paddr, `RSSW_ADDR_EVSTAT);
	wire wr_msk = wr & reg_hit(paddr, `RSSW_ADDR_EVMASK);
	wire sleep_cmd = wr_ctl & pwdata[`RSSW_CT_SLEEP_BIT] & (state_q == ST_RUN);
	wire watchdog_clear_instr_cmd = wr_ctl & pwdata[`RSSW_CT_WATCHDOG_CLEAR_INSTR_BIT];
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~rd_ok;

	logic [7:0] rmux;
	always_comb begin
		case (paddr)
			`RSSW_ADDR_CONFIG: rmux = cfg_q;
			`RSSW_ADDR_INTCTL: rmux = intctl_q;
			`RSSW_ADDR_STATUS: rmux = status_q;
			`RSSW_ADDR_WDTCTL: rmux = wdtctl_q;
			`RSSW_ADDR_EVSTAT: rmux = {4'h0, ev_q};
			`RSSW_ADDR_EVMASK: rmux = evmask_q;
			default: rmux = 8'h00;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= {24'h0, rmux};
		end
	end

	// Start-up sequencer.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_POR: begin
				if (!power_rst) begin
					state_d = cfg.powerup_delay_enable_n ? ST_WAIT_PIN : ST_POWERUP_DELAY_TIMER;
				end
			end
			// counts ignoring pin.
			// The pin is not looked at here, so a long low pin lets the delay expire.
			ST_POWERUP_DELAY_TIMER: begin
				if (cnt_q >= POWERUP_DELAY_TIMER_CYC - 1) begin
					state_d = ST_WAIT_PIN;
				end
			end
			ST_WAIT_PIN: begin
				if (!pin_hold) begin
					state_d = ST_START;
				end
			end
			ST_START: begin
				if (cnt_q >= `RSSW_START_CYC - 1) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sleep_cmd && !wake_pend) state_d = ST_SLEEP;
			end
			// immediate wake.
			// A watchdog expiry in sleep wakes the core instead of resetting it.
			ST_SLEEP: begin
				if (wake_pend || wdt_expired) begin
					state_d = ST_RUN;
				end
			end
			default: state_d = ST_POR;
		endcase
		if (power_rst) begin
			state_d = ST_POR;
		end else if (pin_hold && state_q != ST_POWERUP_DELAY_TIMER && state_q != ST_POR) begin
			state_d = ST_WAIT_PIN;
		end else if (wdt_expired && state_q == ST_RUN) begin
			state_d = ST_WAIT_PIN;
		end
	end

	wire wdt_rst = wdt_expired & (state_q == ST_RUN) & ~power_rst & ~pin_hold;
	wire wake = (state_q == ST_SLEEP) & (state_d == ST_RUN);
	wire entered_sleep = (state_q == ST_RUN) & (state_d == ST_SLEEP);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_POR;
			cnt_q <= 32'h0;
			prog_d_q <= 1'b0;
		end else begin
			state_q <= state_d;
			prog_d_q <= prog_s;
			cnt_q <= (state_d != state_q) ? 32'h0 : cnt_q + 32'h1;
		end
	end

	assign core_reset_n = (state_q == ST_RUN) | (state_q == ST_SLEEP);
	assign sleeping = (state_q == ST_SLEEP);
	assign wdt_clear = wdt_clr_q;

	// Registers.
	wire [`RSSW_EV_W-1:0] ev_set = {core_reset_n == 1'b0 && state_d == ST_RUN,
		pin_hold & core_reset_n, wake, wdt_rst};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= `RSSW_CFG_RESET;
			intctl_q <= `RSSW_IC_RESET;
			status_q <= `RSSW_ST_RESET;
			wdtctl_q <= `RSSW_WDT_RESET;
			evmask_q <= 8'h00;
			ev_q <= '0;
			wdt_clr_q <= 1'b0;
		end else begin
			wdt_clr_q <= watchdog_clear_instr_cmd | entered_sleep | wake | wdt_rst;
			if (wr_cfg) begin
				cfg_q <= pwdata[7:0];
			end
			if (wr_wdt) begin
				wdtctl_q <= {2'b00, pwdata[5:0]};
			end
			if (wr_msk) begin
				evmask_q <= {4'h0, pwdata[3:0]};
			end
			// Hardware flag sets win over a software write in the same cycle.
			if (wr_ic) begin
				intctl_q <= pwdata[7:0] | {5'h00, irq_flag_in};
			end else begin
				intctl_q <= intctl_q | {5'h00, irq_flag_in};
			end
			// Set wins over clear so that an event is never lost to a late clear.
			if (wr_ev) begin
				ev_q <= (ev_q & ~pwdata[`RSSW_EV_W-1:0]) | ev_set;
			end else begin
				ev_q <= ev_q | ev_set;
			end
			if (power_rst) begin
				status_q <= `RSSW_ST_RESET;
			end else if (wdt_rst) begin
				status_q[`RSSW_ST_TO_BIT] <= 1'b0;
				status_q[`RSSW_ST_PD_BIT] <= 1'b1;
			end else if (wake && wdt_expired && !wake_pend) begin
				status_q[`RSSW_ST_TO_BIT] <= 1'b0;
				status_q[`RSSW_ST_PD_BIT] <= 1'b0;
			end else if (wake) begin
				status_q[`RSSW_ST_TO_BIT] <= 1'b1;
				status_q[`RSSW_ST_PD_BIT] <= 1'b0;
			end else if (entered_sleep) begin
				status_q[`RSSW_ST_TO_BIT] <= 1'b1;
				status_q[`RSSW_ST_PD_BIT] <= 1'b0;
			end else if (watchdog_clear_instr_cmd) begin
				status_q[`RSSW_ST_TO_BIT] <= 1'b1;
				status_q[`RSSW_ST_PD_BIT] <= 1'b1;
			end else if (wr_st) begin
				status_q <= {status_q[7:5], status_q[4:3], pwdata[2:0]} | {pwdata[7:5], 5'h00};
			end
		end
	end

	assign irq = |({4'h0, ev_q} & evmask_q);
endmodule

// ---- tb/rssw_pin_src.sv ----
`timescale 1ns/10ps
module rssw_pin_src (
	input wire logic pclk, // bench clock
	output logic pin_n // pin level seen by the device
);
	logic low_q = 1'b0;
	// A released source drives the pin high itself, whatever the pull-up setting, so it always reads high.
	assign pin_n = low_q ? 1'b0 : 1'b1;
	task hold(input logic v);
		@(posedge pclk);
		low_q <= v;
	endtask
	task pulse(input int len);
		hold(1'b1);
		repeat (len) @(posedge pclk);
		low_q <= 1'b0;
	endtask
endmodule

// ---- tb/rssw_ctrl_sva.sv ----
`timescale 1ns/10ps
module rssw_ctrl_sva (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic por_active, // power-on
	input wire logic prog_mode, // programming
	input wire logic wdt_expired, // expiry
	input wire logic ext_reset_pin_n_o, // pin value
	input wire logic ext_reset_pin_n_oe, // pin enable
	input wire logic core_reset_n, // core reset
	input wire logic sleeping, // sleep
	input wire logic wdt_clear // clear pulse
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pin_not_driven: assert property (!ext_reset_pin_n_oe && ext_reset_pin_n_o)
		else $error("reset pin driven");
	a_por_holds_core: assert property (por_active [*4] |=> !core_reset_n)
		else $error("core ran during power-on");
	a_prog_holds_core: assert property (prog_mode [*4] |=> !core_reset_n)
		else $error("core ran during programming");
	a_start_gap: assert property ($rose(core_reset_n) |-> !$past(core_reset_n, 10))
		else $error("start came too early");
	a_wdt_resets: assert property (wdt_expired && core_reset_n && !sleeping |-> ##[1:4] !core_reset_n)
		else $error("no watchdog reset");
	a_clear_pulse: assert property (wdt_clear |=> !wdt_clear)
		else $error("clear pulse too long");
	a_sleep_clears: assert property ($rose(sleeping) |-> wdt_clear || $past(wdt_clear))
		else $error("sleep without clear");
	a_sleep_running: assert property ($rose(sleeping) |-> core_reset_n)
		else $error("sleep while in reset");
endmodule
bind rssw_ctrl rssw_ctrl_sva u_sva (.pclk, .presetn, .por_active, .prog_mode, .wdt_expired,
	.ext_reset_pin_n_o, .ext_reset_pin_n_oe, .core_reset_n, .sleeping, .wdt_clear);

// ---- tb/reset_startup_sleep_wake_ctrl_bench.sv ----
`timescale 1ns/10ps
module reset_startup_sleep_wake_ctrl_bench;
	import rssw_pkg::*;
	rssw_apb_req_s rq;
	logic pclk = 0, presetn, por, bor, prog, wexp, err_q, w;
	logic [2:0] iflag;
	logic [31:0] prdata, rd;
	logic pready, pslverr, pin_o, pin_oe, pin_src, pin_w, pu, gpio, crn, slp, wclr, irq;
	int err_total = 0, checked = 0, n;
	int exp_st = 'h18;
	assign pin_w = pin_oe ? pin_o : pin_src;
	always #10 pclk = ~pclk;
	rssw_pin_src u_pin (.pclk(pclk), .pin_n(pin_src));
	rssw_ctrl #(.POWERUP_DELAY_TIMER_CYC(50), .FILT_CYC(8)) dut (.pclk(pclk), .presetn(presetn),
		.psel(rq.sel), .penable(rq.enable), .pwrite(rq.write), .paddr(rq.addr),
		.pwdata(rq.wdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.por_active(por), .bor_active(bor), .prog_mode(prog), .wdt_expired(wexp),
		.irq_flag_in(iflag), .ext_reset_pin_n_i(pin_w), .ext_reset_pin_n_o(pin_o),
		.ext_reset_pin_n_oe(pin_oe), .pin_pullup_en(pu), .pin_gpio_in(gpio),
		.core_reset_n(crn), .sleeping(slp), .wdt_clear(wclr), .irq(irq));
	task conclude;
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		rq <= '{a, wr, 1'b1, 1'b0, d};
		@(posedge pclk);
		rq.enable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err_q = pslverr;
		rq.sel <= 1'b0;
		rq.enable <= 1'b0;
		if (k >= 50) begin
			err_total++;
			conclude();
		end
		@(negedge pclk);
	endtask
	task wt(input int s, input logic v);
		n = 0;
		while ((s == 0 ? crn : slp) !== v && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) begin
			err_total++;
			conclude();
		end
	endtask
	task pulse_in(input logic f);
		@(posedge pclk);
		if (f) iflag <= 3'h1;
		else wexp <= 1'b1;
		@(posedge pclk);
		iflag <= 3'h0;
		wexp <= 1'b0;
	endtask
	initial begin
		void'($urandom(37));
		rq = '0;
		presetn = 1'b0;
		por = 1'b1;
		bor = 1'b0;
		prog = 1'b0;
		wexp = 1'b0;
		iflag = 3'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		por <= 1'b0;
		wt(0, 1'b1);
		apb(0, 8'h00, 0);
		chk(rd, 32'h04);
		apb(0, 8'h08, 0);
		chk(rd, exp_st);
		apb(0, 8'h1c, 0);
		chk({err_q, rd[30:0]}, 32'h80000000);
		for (int m = 3; m >= 0; m--) begin
			w = 1'($urandom % 2);
			apb(1, 8'h00, m | 4 | (w << 3));
			repeat (4) @(negedge pclk);
			chk(gpio, m == 0);
			chk(pu, m != 0 || w);
		end
		u_pin.hold(1'b1);
		repeat (4) @(negedge pclk);
		chk({gpio, crn}, 2'b01);
		u_pin.hold(1'b0);
		apb(1, 8'h00, 8'h05);
		u_pin.pulse(1 + $urandom % 4);
		repeat (12) @(negedge pclk);
		chk(crn, 1);
		u_pin.hold(1'b1);
		repeat (20) @(negedge pclk);
		chk(crn, 0);
		u_pin.hold(1'b0);
		wt(0, 1'b1);
		apb(1, 8'h14, 4);
		chk(irq, 1);
		apb(1, 8'h14, 0);
		chk(irq, 0);
		apb(1, 8'h14, 4);
		apb(1, 8'h10, 4);
		chk(irq, 0);
		apb(1, 8'h04, 8'h08);
		pulse_in(1'b1);
		apb(1, 8'h18, 1);
		repeat (3) @(negedge pclk);
		chk(slp, 0);
		apb(0, 8'h08, 0);
		chk(rd & 'h18, exp_st);
		apb(1, 8'h04, 8'h08);
		apb(1, 8'h18, 1);
		chk(slp, 1);
		exp_st = 'h10;
		pulse_in(1'b1);
		wt(1, 1'b0);
		chk(n <= 4, 1);
		apb(0, 8'h08, 0);
		chk(rd & 'h18, exp_st);
		pulse_in(1'b0);
		wt(0, 1'b0);
		wt(0, 1'b1);
		exp_st = 'h08;
		apb(0, 8'h08, 0);
		chk(rd & 'h18, exp_st);
		apb(1, 8'h04, 8'h08);
		apb(1, 8'h18, 1);
		chk(slp, 1);
		pulse_in(1'b0);
		wt(1, 1'b0);
		exp_st = 'h00;
		apb(0, 8'h08, 0);
		chk(rd & 'h18, exp_st);
		apb(1, 8'h00, 8'h01);
		@(posedge pclk);
		prog <= 1'b1;
		repeat (6) @(negedge pclk);
		chk(crn, 0);
		@(posedge pclk);
		prog <= 1'b0;
		bor <= 1'b1;
		u_pin.hold(1'b1);
		repeat (10) @(posedge pclk);
		bor <= 1'b0;
		repeat (70) @(negedge pclk);
		chk(crn, 0);
		u_pin.hold(1'b0);
		wt(0, 1'b1);
		chk(n >= 11 && n <= 18, 1);
		@(posedge pclk);
		bor <= 1'b1;
		repeat (5) @(posedge pclk);
		bor <= 1'b0;
		wt(0, 1'b1);
		chk(n >= 60 && n <= 75, 1);
		conclude();
	end
endmodule
